// ===== rtl/tcd_map.svh
// Register offsets, field positions, reset values and limits.
// Included by both RTL module files of the timing command decoder.
`ifndef TCD_MAP_SVH
`define TCD_MAP_SVH

// Byte areas: one byte per aligned word, 8 words each
`define IN_PAGE     7'h00
`define OUT_PAGE    7'h02
`define A_ACK       12'h080
`define A_CFG       12'h084
`define A_YEAR      12'h088
`define A_PER       12'h08C
`define A_DIV       12'h090
`define A_OFS       12'h094
`define A_TIME      12'h098
`define A_UTC       12'h09C
`define A_LEAPT     12'h0A0

`define ACK_DONE_BIT 0
`define ACK_GO_BIT   7

`define C_MODE      8'h10
`define C_FMT       8'h11
`define C_TIME      8'h12
`define C_YEAR      8'h13
`define C_PER       8'h14
`define C_TCF       8'h15
`define C_MOD       8'h16
`define C_OFS       8'h17
`define C_UTC       8'h18
`define C_REQ       8'h19

`define M_TCODE     8'h00
`define M_FREE      8'h01
`define M_PPS       8'h02
`define M_RTC       8'h03
`define M_SAT       8'h06

`define F_BCD       1'h0
`define F_UNIX      1'h1

`define TC_A        8'h41
`define TC_B        8'h42
`define TC_I        8'h49
`define TC_N        8'h4E
`define MOD_AM      8'h4D
`define MOD_DC      8'h44

`define LEAP_DEL    8'hFF
`define LEAP_NONE   8'h00
`define LEAP_ADD    8'h01

`define YEAR_MIN    16'h07B2
`define YEAR_MAX    16'h0802
`define RST_YEAR    16'h0000
`define DAY_MAX     16'h016E
`define HOUR_MAX    8'h17
`define MIN_MAX     8'h3B
`define DIV_MIN     16'h0002
`define OFS_MAX     32'h0098967F

`define STEP_NS     100
`define JAM_NS      1000000
`define JAM_STEPS   (`JAM_NS / `STEP_NS)

`endif

// ===== rtl/tcd_pkg.sv
// Types shared by the timing command decoder.
// Assumes nothing beyond a SystemVerilog compiler.
package tcd_pkg;
    typedef logic [7:0] byte_type;
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_EXEC = 2'h1,
        ST_DONE = 2'h3
    } state_type;
endpackage : tcd_pkg

// ===== rtl/major_time_keeper.sv
// Major time counter with deferred host load and jam-sync detection.
// Assumes one epoch pulse per second, synchronous to clk.
`timescale 1ns/1ps
`include "tcd_map.svh"
module major_time_keeper #(
    parameter int JAM_LIMIT = 10000
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        epoch,
    input  wire logic        bcd_mode,
    input  wire logic        load,
    input  wire logic [31:0] load_value,
    input  wire logic        derive_src,
    input  wire logic        src_valid,
    input  wire logic [31:0] src_time,
    input  wire logic        jam_enable,
    input  wire logic [31:0] ref_diff,
    output logic      [31:0] major_time,
    output logic             jam_sync
);
    logic        pending;
    logic [31:0] pending_value;

    ////////////////////////////////////////////////////////////////////
    // Packed BCD-mode fields: day, hour, minute, second
    wire [5:0]  sec    = major_time[5:0];
    wire [5:0]  min    = major_time[11:6];
    wire [4:0]  hr     = major_time[16:12];
    wire [8:0]  day    = major_time[25:17];
    wire        s_wrap = sec == 6'(`MIN_MAX);
    wire        m_wrap = s_wrap & (min == 6'(`MIN_MAX));
    wire        h_wrap = m_wrap & (hr == 5'(`HOUR_MAX));
    wire        d_wrap = h_wrap & (day == 9'(`DAY_MAX));
    wire [8:0]  nday   = d_wrap ? 9'h000 : (h_wrap ? day + 9'h001 : day);
    wire [4:0]  nhr    = h_wrap ? 5'h00 : (m_wrap ? hr + 5'h01 : hr);
    wire [5:0]  nmin   = m_wrap ? 6'h00 : (s_wrap ? min + 6'h01 : min);
    wire [5:0]  nsec   = s_wrap ? 6'h00 : sec + 6'h01;
    wire [31:0] next_tick = bcd_mode ?
        {6'h00, nday, nhr, nmin, nsec} : major_time + 32'h1;
    wire        src_ovr = src_valid & derive_src;
    wire [31:0] mag = ref_diff[31] ? 32'h0 - ref_diff : ref_diff;
    wire        jam_hit = jam_enable & (mag > 32'(JAM_LIMIT));

    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk) begin
        if (rst) begin
            major_time    <= 32'h0;
            pending       <= 1'b0;
            pending_value <= 32'h0;
            jam_sync      <= 1'b0;
        end else begin
            if (src_ovr) begin
                major_time <= src_time;
                pending    <= 1'b0;
            end else if (epoch) begin
                major_time <= pending ? pending_value : next_tick;
                pending    <= 1'b0;
            end
            // Load in the epoch cycle waits for the following epoch;
            // source time wins over a load in the same cycle
            if (load & ~src_ovr) begin
                pending       <= 1'b1;
                pending_value <= load_value;
            end
            jam_sync <= epoch & jam_hit;
        end
    end

    ////////////////////////////////////////////////////////////////////
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    load_visible_a: assert property (
        epoch && pending && !src_ovr |=> major_time == $past(pending_value))
        else $error("Loaded time not shown at epoch");
    time_hold_a: assert property (
        !epoch && !src_ovr |=> $stable(major_time))
        else $error("Major time changed between epochs");
    src_replace_a: assert property (
        src_ovr |=> major_time == $past(src_time) && !pending)
        else $error("Source time did not replace major time");
    jam_fire_a: assert property (
        epoch && jam_hit |=> jam_sync)
        else $error("Jam-sync missed on large difference");
    jam_quiet_a: assert property (
        !jam_enable |=> !jam_sync)
        else $error("Jam-sync while disabled");
endmodule : major_time_keeper

// ===== rtl/timing_command_decoder.sv
// Timing command decoder: APB-mapped command area, output area,
// handshake register and the timing configuration it maintains.
// Assumes an APB master on CLK and an epoch pulse once a second.
`timescale 1ns/1ps
`include "tcd_map.svh"
module timing_command_decoder
    import tcd_pkg::*;
#(
    parameter logic [7:0] DEFAULT_MODE = `M_TCODE
) (
    input  wire logic        CLK,
    input  wire logic        RST,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    input  wire logic [3:0]  PSTRB,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic        EPOCH,
    input  wire logic        SRC_VALID,
    input  wire logic [31:0] SRC_TIME,
    input  wire logic        JAM_ENABLE,
    input  wire logic [31:0] REF_DIFF,
    output logic      [7:0]  TIMING_MODE,
    output logic             TIME_FORMAT,
    output logic      [15:0] YEAR,
    output logic             SYNC_FLAG,
    output logic      [15:0] FIRST_DIVIDER,
    output logic      [15:0] SECOND_DIVIDER,
    output logic      [7:0]  TC_FORMAT,
    output logic      [7:0]  TC_MODULATION,
    output logic      [31:0] PROP_OFFSET,
    output logic      [31:0] MAJOR_TIME,
    output logic             JAM_SYNC
);
    state_type   state;
    state_type   next_state;
    byte_type    in_area  [8];
    byte_type    out_area [8];
    byte_type    resp     [8];
    logic        ack;
    logic        go_pend;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    byte_type    mode;
    logic        fmt;
    logic [15:0] year;
    logic        sync;
    logic [15:0] div1;
    logic [15:0] div2;
    byte_type    tc_fmt;
    byte_type    tc_mod;
    logic [31:0] offset;
    logic        scale;
    byte_type    leap_cnt;
    byte_type    leap_flag;
    logic [31:0] leap_time;
    logic [31:0] major_time;
    logic        jam_sync;

    ////////////////////////////////////////////////////////////////////
    // APB decode
    wire        acc       = PSEL & PENABLE;
    wire        fire      = acc & pready;
    wire        wr        = fire & PWRITE;
    wire        aligned   = PADDR[1:0] == 2'h0;
    wire [2:0]  bidx      = PADDR[4:2];
    wire        in_hit    = aligned & (PADDR[11:5] == `IN_PAGE);
    wire        out_hit   = aligned & (PADDR[11:5] == `OUT_PAGE);
    wire        ack_hit   = PADDR == `A_ACK;
    wire        cfg_hit   = PADDR == `A_CFG;
    wire        year_hit  = PADDR == `A_YEAR;
    wire        per_hit   = PADDR == `A_PER;
    wire        div_hit   = PADDR == `A_DIV;
    wire        ofs_hit   = PADDR == `A_OFS;
    wire        time_hit  = PADDR == `A_TIME;
    wire        utc_hit   = PADDR == `A_UTC;
    wire        leapt_hit = PADDR == `A_LEAPT;
    wire        hit       = in_hit | out_hit | ack_hit | cfg_hit |
                            year_hit | per_hit | div_hit | ofs_hit |
                            time_hit | utc_hit | leapt_hit;
    wire [31:0] rd_word   =
        in_hit    ? {24'h0, in_area[bidx]} :
        out_hit   ? {24'h0, out_area[bidx]} :
        ack_hit   ? {31'h0, ack} :
        cfg_hit   ? {tc_mod, tc_fmt, 7'h00, fmt, mode} :
        year_hit  ? {16'h0, year} :
        per_hit   ? {31'h0, sync} :
        div_hit   ? {div2, div1} :
        ofs_hit   ? offset :
        time_hit  ? major_time :
        utc_hit   ? {8'h00, leap_flag, leap_cnt, 7'h00, scale} :
        leapt_hit ? leap_time : 32'h0;

    // One wait state keeps every bus output registered
    always_ff @(posedge CLK) begin
        if (RST) begin
            pready  <= 1'b0;
            prdata  <= 32'h0;
            pslverr <= 1'b0;
        end else begin
            pready  <= acc & ~pready;
            prdata  <= (acc & ~pready & ~PWRITE) ? rd_word : 32'h0;
            pslverr <= acc & ~pready & ~hit;
        end
    end

    // Input area is host-written only; no reset, host fills it first
    always_ff @(posedge CLK) begin
        if (wr & in_hit & PSTRB[0]) begin
            in_area[bidx] <= PWDATA[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Handshake register
    wire ack_wr  = wr & ack_hit & PSTRB[0];
    wire ack_clr = ack_wr & PWDATA[`ACK_DONE_BIT];
    wire go_wr   = ack_wr & PWDATA[`ACK_GO_BIT];
    wire start   = (state == ST_IDLE) & go_pend;
    wire done    = state == ST_DONE;
    wire exec    = state == ST_EXEC;

    always_ff @(posedge CLK) begin
        if (RST) begin
            ack     <= 1'b0;
            go_pend <= 1'b0;
        end else begin
            ack     <= done | (ack & ~ack_clr);
            go_pend <= go_wr | (go_pend & ~start);
        end
    end

    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: if (go_pend) begin
                next_state = ST_EXEC;
            end
            ST_EXEC: next_state = ST_DONE;
            ST_DONE: next_state = ST_IDLE;
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Command field decode, most significant byte first
    wire [7:0]  id    = in_area[0];
    wire [7:0]  b1    = in_area[1];
    wire [7:0]  b3    = in_area[3];
    wire [7:0]  b5    = in_area[5];
    wire [7:0]  b6    = in_area[6];
    wire [7:0]  b7    = in_area[7];
    wire [15:0] w12   = {in_area[1], in_area[2]};
    wire [15:0] w23   = {in_area[2], in_area[3]};
    wire [15:0] w34   = {in_area[3], in_area[4]};
    wire [15:0] w45   = {in_area[4], in_area[5]};
    wire [31:0] w1234 = {in_area[1], in_area[2], in_area[3], in_area[4]};
    wire [31:0] w4567 = {in_area[4], in_area[5], in_area[6], in_area[7]};

    wire year_ok = (w12 >= `YEAR_MIN) & (w12 <= `YEAR_MAX);
    wire mode_ok = (b1 == `M_TCODE) | (b1 == `M_FREE) |
                   (b1 == `M_PPS) | (b1 == `M_RTC) | (b1 == `M_SAT);
    wire fmt_ok  = b1 <= 8'h01;
    wire bcd_ok  = year_ok & (w34 <= `DAY_MAX) &
                   (b5 <= `HOUR_MAX) & (b6 <= `MIN_MAX) &
                   (b7 <= `MIN_MAX);
    wire time_ok = (fmt == `F_UNIX) | bcd_ok;
    wire per_ok  = (b1 <= 8'h01) & (w23 >= `DIV_MIN) &
                   (w45 >= `DIV_MIN);
    wire tcf_ok  = (b1 == `TC_A) | (b1 == `TC_B) |
                   (b1 == `TC_I) | (b1 == `TC_N);
    wire mod_ok  = (b1 == `MOD_AM) | (b1 == `MOD_DC);
    wire ofs_ok  = ($signed(w1234) <= $signed(`OFS_MAX)) &
                   ($signed(w1234) >= -$signed(`OFS_MAX));
    wire utc_ok  = (b1 <= 8'h01) & ((b3 == `LEAP_DEL) |
                   (b3 == `LEAP_NONE) | (b3 == `LEAP_ADD));

    wire do_mode = exec & (id == `C_MODE) & mode_ok;
    wire do_fmt  = exec & (id == `C_FMT) & fmt_ok;
    wire do_time = exec & (id == `C_TIME) & time_ok;
    wire do_year = exec & (((id == `C_YEAR) & year_ok) |
                   (do_time & (fmt == `F_BCD)));
    wire do_per  = exec & (id == `C_PER) & per_ok;
    wire do_tcf  = exec & (id == `C_TCF) & tcf_ok;
    wire do_mod  = exec & (id == `C_MOD) & mod_ok;
    wire do_ofs  = exec & (id == `C_OFS) & ofs_ok;
    wire do_utc  = exec & (id == `C_UTC) & utc_ok;
    wire do_req  = exec & (id == `C_REQ);

    // UNIX: whole seconds; BCD: packed day/hour/minute/second
    wire [31:0] load_value = (fmt == `F_UNIX) ? w1234 :
        {6'h00, w34[8:0], b5[4:0], b6[5:0], b7[5:0]};
    // Host time only holds where no reference source drives it
    wire derive_src = (mode == `M_TCODE) | (mode == `M_RTC) |
                      (mode == `M_SAT);

    ////////////////////////////////////////////////////////////////////
    // Configuration; rejected values leave the old setting
    always_ff @(posedge CLK) begin
        if (RST) begin
            mode      <= DEFAULT_MODE;
            fmt       <= `F_UNIX;
            year      <= `RST_YEAR;
            sync      <= 1'b0;
            div1      <= `DIV_MIN;
            div2      <= `DIV_MIN;
            tc_fmt    <= `TC_B;
            tc_mod    <= `MOD_AM;
            offset    <= 32'h0;
            scale     <= 1'b0;
            leap_cnt  <= 8'h00;
            leap_flag <= `LEAP_NONE;
            leap_time <= 32'h0;
        end else begin
            if (do_mode) begin
                mode <= b1;
            end
            if (do_fmt) begin
                fmt <= b1[0];
            end
            if (do_year) begin
                year <= w12;
            end
            if (do_per) begin
                sync <= b1[0];
                div1 <= w23;
                div2 <= w45;
            end
            if (do_tcf) begin
                tc_fmt <= b1;
            end
            if (do_mod) begin
                tc_mod <= b1;
            end
            if (do_ofs) begin
                offset <= w1234;
            end
            if (do_utc) begin
                scale     <= b1[0];
                leap_cnt  <= in_area[2];
                leap_flag <= b3;
                leap_time <= w4567;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Request-data response, written in the execute cycle
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            resp[i] = 8'h00;
        end
        resp[0] = b1;
        unique case (b1)
            `C_MODE: resp[1] = mode;
            `C_FMT:  resp[1] = {7'h00, fmt};
            `C_TIME: {resp[1], resp[2], resp[3], resp[4]} = major_time;
            `C_YEAR: {resp[1], resp[2]} = year;
            `C_PER: begin
                resp[1] = {7'h00, sync};
                {resp[2], resp[3]} = div1;
                {resp[4], resp[5]} = div2;
            end
            `C_TCF:  resp[1] = tc_fmt;
            `C_MOD:  resp[1] = tc_mod;
            `C_OFS:  {resp[1], resp[2], resp[3], resp[4]} = offset;
            `C_UTC: begin
                resp[1] = {7'h00, scale};
                resp[2] = leap_cnt;
                resp[3] = leap_flag;
                {resp[4], resp[5], resp[6], resp[7]} = leap_time;
            end
            default: resp[1] = 8'h00;
        endcase
    end

    // Filled one cycle ahead of the acknowledge, so data is never stale
    always_ff @(posedge CLK) begin
        if (RST) begin
            for (int i = 0; i < 8; i++) begin
                out_area[i] <= 8'h00;
            end
        end else if (do_req) begin
            for (int i = 0; i < 8; i++) begin
                out_area[i] <= resp[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    major_time_keeper #(
        .JAM_LIMIT  (`JAM_STEPS)
    ) u_keeper (
        .clk        (CLK),
        .rst        (RST),
        .epoch      (EPOCH),
        .bcd_mode   (fmt == `F_BCD),
        .load       (do_time),
        .load_value (load_value),
        .derive_src (derive_src),
        .src_valid  (SRC_VALID),
        .src_time   (SRC_TIME),
        .jam_enable (JAM_ENABLE),
        .ref_diff   (REF_DIFF),
        .major_time (major_time),
        .jam_sync   (jam_sync)
    );

    assign PRDATA         = prdata;
    assign PREADY         = pready;
    assign PSLVERR        = pslverr;
    assign TIMING_MODE    = mode;
    assign TIME_FORMAT    = fmt;
    assign YEAR           = year;
    assign SYNC_FLAG      = sync;
    assign FIRST_DIVIDER  = div1;
    assign SECOND_DIVIDER = div2;
    assign TC_FORMAT      = tc_fmt;
    assign TC_MODULATION  = tc_mod;
    assign PROP_OFFSET    = offset;
    assign MAJOR_TIME     = major_time;
    assign JAM_SYNC       = jam_sync;

    ////////////////////////////////////////////////////////////////////
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);

    sequence s_req;
        exec && id == `C_REQ;
    endsequence
    sequence s_filled;
        out_area[0] == $past(b1) && !ack;
    endsequence

    resp_first_a: assert property (
        s_req ##0 !ack |=> s_filled ##1 ack)
        else $error("Response not in place before acknowledge");
    ack_set_a: assert property (
        done |=> ack)
        else $error("Acknowledge not set after command");
    ack_only_dev_a: assert property (
        !ack && !done |=> !ack)
        else $error("Acknowledge set without a command");
    mode_set_a: assert property (
        exec && id == `C_MODE && mode_ok |=> TIMING_MODE == $past(b1))
        else $error("Timing mode not taken");
    mode_keep_a: assert property (
        exec && id == `C_MODE && !mode_ok |=> $stable(TIMING_MODE))
        else $error("Bad timing mode accepted");
    ofs_range_a: assert property (
        exec && id == `C_OFS && !ofs_ok |=> $stable(PROP_OFFSET))
        else $error("Offset out of range accepted");
    reset_vals_a: assert property (
        $past(RST) |-> TIME_FORMAT == `F_UNIX && TC_FORMAT == `TC_B &&
            TC_MODULATION == `MOD_AM && PROP_OFFSET == 32'h0)
        else $error("Reset defaults wrong");
    go_to_ack_a: assert property (
        go_wr && state == ST_IDLE && !go_pend |=> ##3 ack)
        else $error("Command not acknowledged in time");
endmodule : timing_command_decoder

// ===== testbench/ref_model.sv
// Reference side model: second epochs and source time stamps.
// Assumes the bench requests each pulse for one cycle.
`timescale 1ns/1ps
module ref_model (
    input  wire logic        clk,
    input  wire logic        tick,
    input  wire logic        srcv,
    input  wire logic [31:0] t,
    output logic             epoch,
    output logic             src_valid,
    output logic [31:0]      src_time
);
    initial {epoch, src_valid, src_time} = '0;
    always @(posedge clk) begin
        epoch     <= tick;
        src_valid <= srcv;
        // Stale stamp is inverted each cycle, so it reads as the last valid time again every second cycle
        src_time  <= srcv ? t : ~src_time;
    end
endmodule : ref_model

// ===== testbench/test_timing_command_decoder.sv
// Self-checking bench for the timing command decoder over APB.
// Assumes ref_model supplies epoch and source time pulses.
`timescale 1ns/1ps
`include "tcd_map.svh"
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin n_errors++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, a, e); end end
module test_timing_command_decoder;
    logic        CLK = 0, RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0;
    logic [11:0] PADDR = 0;
    logic [31:0] PWDATA = 0, PRDATA, SRC_TIME, PROP_OFFSET, MAJOR_TIME;
    logic [31:0] RD, r, REF_DIFF = 0;
    logic [3:0]  PSTRB = 4'hF;
    logic        PREADY, PSLVERR, EPOCH, SRC_VALID, TIME_FORMAT, SYNC_FLAG;
    logic        JAM_SYNC, JAM_ENABLE = 0, tick = 0, srcv = 0;
    logic [7:0]  TIMING_MODE, TC_FORMAT, TC_MODULATION, v;
    logic [15:0] YEAR, FIRST_DIVIDER, SECOND_DIVIDER, n1, y;
    logic [64:0] q[$], e;
    logic [63:0] us[2];
    logic        jexp = 0, jx, ep = 0, jq[$];
    int          n_errors = 0, n_tests = 0, seed = 42877;
    int          ys[4] = '{1969, 1970, 2051, 2050};
    always #2 CLK = ~CLK;
    timing_command_decoder timing_command_decoder_inst (.CLK, .RST, .PSEL,
        .PENABLE, .PWRITE, .PADDR, .PWDATA, .PSTRB, .PRDATA, .PREADY,
        .PSLVERR, .EPOCH, .SRC_VALID, .SRC_TIME, .JAM_ENABLE, .REF_DIFF,
        .TIMING_MODE, .TIME_FORMAT, .YEAR, .SYNC_FLAG, .FIRST_DIVIDER,
        .SECOND_DIVIDER, .TC_FORMAT, .TC_MODULATION, .PROP_OFFSET,
        .MAJOR_TIME, .JAM_SYNC);
    ref_model ref_model_inst (.clk(CLK), .tick, .srcv, .t(r),
        .epoch(EPOCH), .src_valid(SRC_VALID), .src_time(SRC_TIME));
    ////////////////////////////////////////////////////////////////////
    // Read results are matched against notes in arrival order
    always @(posedge CLK) if (PSEL && PENABLE && PREADY && !PWRITE) begin
        e = q.pop_front();
        if (e[64:33] != 0) `CHK({PSLVERR, PRDATA & e[64:33]}, e[32:0])
    end
    // Jam pulse is due the cycle after each epoch
    always @(posedge CLK) begin
        if (ep) begin
            jx = jq.pop_front();
            `CHK(JAM_SYNC, jx)
        end
        ep <= EPOCH;
    end
    task results;
        $display("errors %0d tests %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : results
    task bus(input logic w, input logic [11:0] a, input logic [31:0] d,
             input logic [31:0] m, input logic [32:0] x);
        int k;
        if (!w) q.push_back({m, x});
        PSEL <= 1; PWRITE <= w; PADDR <= a; PWDATA <= d;
        @(posedge CLK) PENABLE <= 1;
        k = 0;
        do begin @(posedge CLK); k++; end while (PREADY !== 1 && k < 50);
        if (PREADY !== 1) begin n_errors++; results(); end
        RD = PRDATA;
        PSEL <= 0; PENABLE <= 0;
        @(posedge CLK);
    endtask : bus
    task rd(input logic [11:0] a, input logic [31:0] m, x);
        bus(0, a, 0, m, {1'b0, x});
    endtask : rd
    task cmd(input logic [63:0] b);
        int k;
        for (int i = 0; i < 8; i++) bus(1, 12'(4*i), 32'(b[63-8*i -: 8]), 0, 0);
        bus(1, `A_ACK, 32'h01, 0, 0);
        bus(1, `A_ACK, 32'h80, 0, 0);
        k = 0;
        do begin bus(0, `A_ACK, 0, 0, 0); k++; end while (RD[0] !== 1 && k < 20);
        if (RD[0] !== 1) begin n_errors++; results(); end
    endtask : cmd
    task pulse(input logic s);
        if (!s) jq.push_back(jexp);
        {tick, srcv} <= s ? 2'b01 : 2'b10;
        @(posedge CLK) {tick, srcv} <= 0;
        repeat (3) @(posedge CLK);
    endtask : pulse
    ////////////////////////////////////////////////////////////////////
    initial begin
        r = $random(seed);
        repeat (5) @(posedge CLK);
        RST <= 0;
        @(posedge CLK);
        rd(`A_CFG, '1, 32'h4D42_0100);
        rd(`A_DIV, '1, 32'h0002_0002);
        bus(0, 12'h0FC, 0, '1, {1'b1, 32'h0});
        v = 0;
        for (int c = 0; c < 8; c++) begin
            cmd({8'h10, 8'(c), 48'h0});
            if (c inside {0, 1, 2, 3, 6}) v = 8'(c);
            rd(`A_CFG, 32'hFF, 32'(v));
        end
        v = 8'h42;
        for (int c = 'h40; c < 'h50; c++) begin
            cmd({8'h15, 8'(c), 48'h0});
            if (c inside {'h41, 'h42, 'h49, 'h4E}) v = 8'(c);
            rd(`A_CFG, 32'hFF0000, {8'h0, v, 16'h0});
        end
        v = 8'h4D;
        for (int c = 'h43; c < 'h4F; c++) begin
            cmd({8'h16, 8'(c), 48'h0});
            if (c inside {'h44, 'h4D}) v = 8'(c);
            rd(`A_CFG, 32'hFF000000, {v, 24'h0});
        end
        for (int i = 0; i < 3; i++) begin
            cmd({8'h11, 8'((2*i)%3), 48'h0});
            rd(`A_CFG, 32'h100, {23'h0, i == 2, 8'h0});
        end
        y = 0;
        foreach (ys[i]) begin
            cmd({8'h13, 16'(ys[i]), 40'h0});
            if (ys[i] inside {[1970:2050]}) y = 16'(ys[i]);
            rd(`A_YEAR, 32'hFFFF, {16'h0, y});
        end
        n1 = r[15:0] | 16'h2;
        cmd({8'h14, 8'h01, n1, 16'hFFFF, 16'h0});
        cmd({8'h14, 8'h01, 16'h0001, 16'h0002, 16'h0});
        rd(`A_DIV, '1, {16'hFFFF, n1});
        rd(`A_PER, 32'h1, 32'h1);
        cmd({8'h17, 32'(-9999999), 24'h0});
        cmd({8'h17, 32'd10000000, 24'h0});
        rd(`A_OFS, '1, 32'(-9999999));
        cmd({8'h10, 8'h01, 48'h0});
        pulse(0);
        // Load right after an epoch, well before 800 ms
        cmd({8'h12, r, 24'h0});
        rd(`A_TIME, '1, 32'h1);
        pulse(0);
        rd(`A_TIME, '1, r);
        pulse(0);
        pulse(1);
        rd(`A_TIME, '1, r + 1);
        cmd({8'h10, 8'h06, 48'h0});
        r = $random(seed);
        pulse(1);
        rd(`A_TIME, '1, r);
        JAM_ENABLE <= 1;
        REF_DIFF <= 32'd10001 + 32'(r[7:0]);
        jexp = 1;
        pulse(0);
        REF_DIFF <= -32'sd10000;
        jexp = 0;
        pulse(0);
        JAM_ENABLE <= 0;
        REF_DIFF <= 32'h8000_0000;
        pulse(0);
        rd(`A_TIME, '1, r + 3);
        cmd({8'h11, 8'h00, 48'h0});
        cmd({8'h12, 16'd2000, 16'h016E, 8'h17, 8'h3B, 8'h3B});
        pulse(0);
        rd(`A_TIME, '1, {6'h0, 9'h16E, 5'h17, 6'h3B, 6'h3B});
        pulse(0);
        rd(`A_TIME, '1, 32'h0);
        cmd({8'h18, 8'h01, 8'h05, 8'hFF, r});
        cmd({8'h18, 8'h00, 8'h07, 8'h02, r});
        rd(`A_UTC, '1, 32'h00FF_0501);
        us[0] = {8'h13, 16'h07D0, 40'h0};
        us[1] = {8'h18, 8'h01, 8'h05, 8'hFF, r};
        foreach (us[j]) begin
            cmd({8'h19, us[j][63:56], 48'h0});
            for (int i = 0; i < 8; i++)
                rd(12'(64 + 4*i), 32'hFF, 32'(us[j][63-8*i -: 8]));
        end
        `CHK({TIMING_MODE, TC_FORMAT, TC_MODULATION}, 24'h064E4D)
        `CHK({TIME_FORMAT, SYNC_FLAG, YEAR}, 18'h107D0)
        `CHK({SECOND_DIVIDER, FIRST_DIVIDER}, {16'hFFFF, n1})
        `CHK(PROP_OFFSET, 32'(-9999999))
        `CHK(MAJOR_TIME, 32'h0)
        results();
    end
endmodule : test_timing_command_decoder
